// file: icp_pkg.sv
// Shared constants and types of the two-wire register control port.
package icp_pkg;

   // ******************************************************************
   // Bus addressing and framing
   // ******************************************************************

   // Upper six address bits; the lowest bit comes from the strap pin.
   localparam logic [5:0] DEV_ADDR_HI = 6'h36;
   // Bit count at which a received byte is complete.
   localparam logic [3:0] LAST_BIT = 4'h8;
   // Falling edge count at which the last transmitted bit is on the bus.
   localparam logic [3:0] TX_LAST = 4'h7;
   // Cycles waited after reset before the strap pin is captured.
   localparam logic [2:0] LATCH_WAIT = 3'h7;
   // Gain-select pin level that selects software control mode.
   localparam logic [1:0] SW_MODE_PINS = 2'h3;

   // ******************************************************************
   // Bus rates and sampling margin
   // ******************************************************************

   localparam int STD_RATE_KHZ = 100;
   localparam int FAST_RATE_KHZ = 400;
   // Shortest clock high time at the fast rate, in ns.
   localparam int FAST_HIGH_NS = 600;
   // Link clock cycles that a clock high phase must span at least.
   localparam int MIN_HIGH_CYC = 4;

   // ******************************************************************
   // Register file
   // ******************************************************************

   localparam int NUM_REGS_DEF = 18;
   localparam logic [7:0] DEV_ID_IDX = 8'h00;
   localparam logic [7:0] ANA_CTRL_IDX = 8'h06;
   localparam logic [7:0] ANA_CTRL_RST = 8'h51;
   localparam int AGAIN_LSB = 2;
   localparam int AGAIN_MSB = 3;

   // ******************************************************************
   // Link state machine
   // ******************************************************************

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX   = 5'b00010,
      ST_ACK  = 5'b00100,
      ST_TX   = 5'b01000,
      ST_MACK = 5'b10000
   } icp_state_t;

endpackage

// file: icp_sync.sv
// Three-stage synchroniser whose output moves when stages two and three agree.
`timescale 1ns/1ps
module icp_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Data
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   // ******************************************************************
   // State
   // ******************************************************************

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } icp_sync_t;

   icp_sync_t st_r;
   icp_sync_t st_nxt;

   // A zero-width synchroniser has nothing to carry.
   if (WIDTH < 1)
   begin : g_bad_width
      $error("icp_sync needs at least one bit");
   end

   // Stage one is read only by stage two; the filter looks at two and three.
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = d_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.q = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 | st_r.s3));
      if (rst_in)
      begin
         st_nxt = '0;
      end
   end

   // State register.
   always_ff @(posedge clk_in)
   begin
      st_r <= st_nxt;
   end

   assign q_out = st_r.q;

endmodule

// file: icp_ctrl_port.sv
// Slave-only two-wire control port with its byte-wide register file.
// Operation
// - Strap pin level captured after power-up reset sets address bit 0.
// - Works at 100 kHz and 400 kHz bus clock rates.
// - Slave only; never drives the clock line nor stretches it.
// - Bytes are eight bits, MSB first, each followed by an acknowledge bit.
// - Data falling with clock high is start; rising with clock high is stop.
// - Data line changes only while the clock line is low.
// - Device acknowledges by holding data low through the acknowledge period.
// - Any number of bytes between start and stop; stop releases the bus.
// - Write: address, index, data, each acknowledged; data stored at index.
// - Read: index written, repeated start, read address, device sends byte.
// - In software mode analog gain comes from bits 3:2 of a register.
// - Both gain pins high selects software mode and enables the bus port.
`timescale 1ns/1ps
module icp_ctrl_port #(
   parameter int NUM_REGS = icp_pkg::NUM_REGS_DEF,
   parameter int LINK_CLK_NS = 30,
   // Identification value is arbitrary.
   parameter logic [7:0] DEVICE_ID = 8'ha5
) (
   // System clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Link sampling clock
   input wire logic link_clk_in,
   // Strap and mode pins
   input wire logic sleep_address_select_pin_in,
   input wire logic [1:0] gain_select_pins_in,
   // Two-wire bus: clock is only read, data is open drain
   input wire logic bridge_mode_or_bus_clock_pin_in,
   input wire logic switch_freq_or_bus_data_pin_in,
   output logic switch_freq_or_bus_data_pin_out,
   output logic switch_freq_or_bus_data_pin_oe_out,
   // Block outputs
   output logic sw_mode_out,
   output logic [1:0] analog_gain_out
);
   import icp_pkg::*;

   // ******************************************************************
   // Elaboration checks
   // ******************************************************************

   localparam int FAST_HIGH_CYC = FAST_HIGH_NS / LINK_CLK_NS;
   localparam logic [8:0] NREG9 = 9'(NUM_REGS);

   if (NUM_REGS <= int'(ANA_CTRL_IDX) || NUM_REGS > 256)
   begin : g_bad_regs
      $error("NUM_REGS must hold the analog control register and fit 8 bits");
   end
   // A slow link clock would miss fast-mode clock high phases.
   if (FAST_HIGH_CYC < MIN_HIGH_CYC)
   begin : g_bad_clk
      $error("link clock too slow for the fast bus rate");
   end

   // ******************************************************************
   // State of both domains
   // ******************************************************************

   typedef struct packed {
      icp_state_t st;
      logic [3:0] bitcnt;
      logic [1:0] bytenum;
      logic rw;
      logic nack;
      logic [7:0] sh;
      logic [7:0] idx;
      logic scl_q;
      logic sda_q;
      logic adr_lsb;
      logic [2:0] wait_cnt;
      logic ready;
      logic oe;
      logic req_tgl;
      logic req_we;
      logic [7:0] req_widx;
      logic [7:0] req_wdata;
      logic [7:0] req_ridx;
      logic [7:0] rdata;
      logic ack_q;
   } icp_link_t;

   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      logic [7:0] rdata;
      logic req_q;
      logic ack_tgl;
      logic sw_mode;
      logic [1:0] gain;
   } icp_ref_t;

   icp_link_t l_r;
   icp_link_t l_nxt;
   icp_ref_t r_r;
   icp_ref_t r_nxt;

   logic link_rst;
   logic [5:0] lk_f;
   logic [2:0] rf_f;
   logic scl_f;
   logic sda_f;
   logic ack_f;
   logic sw_mode_l;
   logic act;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   // ******************************************************************
   // Clock domain crossings
   // ******************************************************************

   // The link domain leaves reset a few link cycles after the system does.
   icp_sync #(.WIDTH(1)) u_rst_sync (
      .clk_in(link_clk_in),
      .rst_in(1'b0),
      .d_in(sys_rst_in),
      .q_out(link_rst)
   );

   // Pins and the answer toggle enter the link domain together.
   icp_sync #(.WIDTH(6)) u_link_sync (
      .clk_in(link_clk_in),
      .rst_in(link_rst),
      .d_in({gain_select_pins_in, sleep_address_select_pin_in,
             bridge_mode_or_bus_clock_pin_in, switch_freq_or_bus_data_pin_in,
             r_r.ack_tgl}),
      .q_out(lk_f)
   );

   // Gain pins and the request toggle enter the system domain.
   icp_sync #(.WIDTH(3)) u_ref_sync (
      .clk_in(ref_clk_in),
      .rst_in(sys_rst_in),
      .d_in({gain_select_pins_in, l_r.req_tgl}),
      .q_out(rf_f)
   );

   // ******************************************************************
   // Link domain: bus conditions
   // ******************************************************************

   // Clock and data share one synchroniser delay, so their order is kept.
   assign scl_f = lk_f[2];
   assign sda_f = lk_f[1];
   assign ack_f = lk_f[0];
   assign sw_mode_l = (lk_f[5:4] == SW_MODE_PINS);
   assign act = l_r.ready & sw_mode_l;
   assign scl_rise = scl_f & ~l_r.scl_q;
   assign scl_fall = ~scl_f & l_r.scl_q;
   assign start_c = scl_f & l_r.scl_q & l_r.sda_q & ~sda_f;
   assign stop_c = scl_f & l_r.scl_q & ~l_r.sda_q & sda_f;

   // ******************************************************************
   // Link domain: protocol engine
   // ******************************************************************

   // One pass per link cycle; all bus moves key off filtered edges.
   always_comb
   begin
      l_nxt = l_r;
      l_nxt.scl_q = scl_f;
      l_nxt.sda_q = sda_f;
      // Answer word is stable before its toggle is seen here.
      if (ack_f != l_r.ack_q)
      begin
         l_nxt.ack_q = ack_f;
         l_nxt.rdata = r_r.rdata;
      end
      if (!l_r.ready)
      begin
         l_nxt.wait_cnt = l_r.wait_cnt + 3'h1;
         if (l_r.wait_cnt == LATCH_WAIT)
         begin
            l_nxt.ready = 1'b1;
            l_nxt.adr_lsb = lk_f[3];
         end
      end
      else if (!sw_mode_l)
      begin
         // In hardware mode the shared pins belong to other functions.
         l_nxt.st = ST_IDLE;
         l_nxt.oe = 1'b0;
      end
      else if (start_c)
      begin
         l_nxt.st = ST_RX;
         l_nxt.bitcnt = 4'h0;
         l_nxt.bytenum = 2'h0;
         l_nxt.oe = 1'b0;
      end
      else if (stop_c)
      begin
         l_nxt.st = ST_IDLE;
         l_nxt.oe = 1'b0;
      end
      else
      begin
         unique case (l_r.st)
            ST_IDLE:
            begin
               l_nxt.oe = 1'b0;
            end
            ST_RX:
            begin
               if (scl_rise)
               begin
                  l_nxt.sh = {l_r.sh[6:0], sda_f};
                  l_nxt.bitcnt = l_r.bitcnt + 4'h1;
               end
               else if (scl_fall && l_r.bitcnt == LAST_BIT)
               begin
                  l_nxt.bitcnt = 4'h0;
                  if (l_r.bytenum == 2'h0)
                  begin
                     // Only our own address is answered.
                     if (l_r.sh[7:1] == {DEV_ADDR_HI, l_r.adr_lsb})
                     begin
                        l_nxt.rw = l_r.sh[0];
                        l_nxt.bytenum = 2'h1;
                        l_nxt.st = ST_ACK;
                        l_nxt.oe = 1'b1;
                     end
                     else
                     begin
                        l_nxt.st = ST_IDLE;
                     end
                  end
                  else
                  begin
                     l_nxt.st = ST_ACK;
                     l_nxt.oe = 1'b1;
                     l_nxt.req_tgl = ~l_r.req_tgl;
                     if (l_r.bytenum == 2'h1)
                     begin
                        // Index byte; prefetch the indexed register.
                        l_nxt.idx = l_r.sh;
                        l_nxt.req_we = 1'b0;
                        l_nxt.req_ridx = l_r.sh;
                        l_nxt.bytenum = 2'h2;
                     end
                     else
                     begin
                        // Data byte; later bytes go to following indices.
                        l_nxt.req_we = 1'b1;
                        l_nxt.req_widx = l_r.idx;
                        l_nxt.req_wdata = l_r.sh;
                        l_nxt.idx = l_r.idx + 8'h01;
                        l_nxt.req_ridx = l_r.idx + 8'h01;
                     end
                  end
               end
            end
            ST_ACK:
            begin
               // Data is held low until the acknowledge clock has fallen.
               if (scl_fall)
               begin
                  if (l_r.rw)
                  begin
                     l_nxt.st = ST_TX;
                     l_nxt.sh = l_r.rdata;
                     l_nxt.oe = ~l_r.rdata[7];
                     l_nxt.bitcnt = 4'h0;
                  end
                  else
                  begin
                     l_nxt.st = ST_RX;
                     l_nxt.oe = 1'b0;
                  end
               end
            end
            ST_TX:
            begin
               if (scl_fall)
               begin
                  if (l_r.bitcnt == TX_LAST)
                  begin
                     // Release for the master's answer and fetch the next byte.
                     l_nxt.st = ST_MACK;
                     l_nxt.oe = 1'b0;
                     l_nxt.idx = l_r.idx + 8'h01;
                     l_nxt.req_we = 1'b0;
                     l_nxt.req_ridx = l_r.idx + 8'h01;
                     l_nxt.req_tgl = ~l_r.req_tgl;
                  end
                  else
                  begin
                     l_nxt.sh = {l_r.sh[6:0], 1'b0};
                     l_nxt.oe = ~l_r.sh[6];
                     l_nxt.bitcnt = l_r.bitcnt + 4'h1;
                  end
               end
            end
            ST_MACK:
            begin
               if (scl_rise)
               begin
                  l_nxt.nack = sda_f;
               end
               else if (scl_fall)
               begin
                  if (l_r.nack)
                  begin
                     l_nxt.st = ST_IDLE;
                  end
                  else
                  begin
                     l_nxt.st = ST_TX;
                     l_nxt.sh = l_r.rdata;
                     l_nxt.oe = ~l_r.rdata[7];
                     l_nxt.bitcnt = 4'h0;
                  end
               end
            end
            default:
            begin
               l_nxt.st = ST_IDLE;
               l_nxt.oe = 1'b0;
            end
         endcase
      end
      if (link_rst)
      begin
         l_nxt = '0;
         l_nxt.st = ST_IDLE;
      end
   end

   // Link domain state register.
   always_ff @(posedge link_clk_in)
   begin
      l_r <= l_nxt;
   end

   // ******************************************************************
   // System domain: register file and gain
   // ******************************************************************

   // A request toggle carries words that stay frozen until it is answered.
   always_comb
   begin
      r_nxt = r_r;
      r_nxt.sw_mode = (rf_f[2:1] == SW_MODE_PINS);
      // The analog gain follows the register only in software mode.
      if (r_nxt.sw_mode)
      begin
         r_nxt.gain = r_r.regs[ANA_CTRL_IDX][AGAIN_MSB:AGAIN_LSB];
      end
      else
      begin
         r_nxt.gain = rf_f[2:1];
      end
      if (rf_f[0] != r_r.req_q)
      begin
         r_nxt.req_q = rf_f[0];
         r_nxt.ack_tgl = rf_f[0];
         if (l_r.req_we && {1'b0, l_r.req_widx} < NREG9 && l_r.req_widx != DEV_ID_IDX)
         begin
            r_nxt.regs[l_r.req_widx] = l_r.req_wdata;
         end
         if (l_r.req_ridx == DEV_ID_IDX)
         begin
            r_nxt.rdata = DEVICE_ID;
         end
         else if ({1'b0, l_r.req_ridx} < NREG9)
         begin
            r_nxt.rdata = r_nxt.regs[l_r.req_ridx];
         end
         else
         begin
            r_nxt.rdata = 8'h00;
         end
      end
      if (sys_rst_in)
      begin
         r_nxt = '0;
         r_nxt.regs[ANA_CTRL_IDX] = ANA_CTRL_RST;
      end
   end

   // System domain state register.
   always_ff @(posedge ref_clk_in)
   begin
      r_r <= r_nxt;
   end

   // ******************************************************************
   // Outputs
   // ******************************************************************

   // Open drain: the pin is only ever pulled low, never driven high.
   assign switch_freq_or_bus_data_pin_out = 1'b0;
   assign switch_freq_or_bus_data_pin_oe_out = l_r.oe;
   assign sw_mode_out = r_r.sw_mode;
   assign analog_gain_out = r_r.gain;

   // ******************************************************************
   // Assertions
   // ******************************************************************

   property p_sw_gate;
      @(posedge link_clk_in) disable iff (link_rst) !sw_mode_l |=> !l_r.oe;
   endproperty
   a_sw_gate: assert property (p_sw_gate)
      else $error("data driven outside software mode");

   property p_ack_drive;
      @(posedge link_clk_in) disable iff (link_rst) (l_r.st == ST_ACK) |-> l_r.oe;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("acknowledge not held low");

   property p_oe_scl_low;
      @(posedge link_clk_in) disable iff (link_rst) $rose(l_r.oe) |-> !l_r.scl_q;
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("data pulled low while clock high");

   property p_slave_only;
      @(posedge link_clk_in) disable iff (link_rst)
         l_r.oe |-> (l_r.st == ST_ACK || l_r.st == ST_TX);
   endproperty
   a_slave_only: assert property (p_slave_only)
      else $error("data driven outside acknowledge or read byte");

   property p_start;
      @(posedge link_clk_in) disable iff (link_rst)
         (start_c && act) |=> (l_r.st == ST_RX && l_r.bitcnt == 4'h0 && !l_r.oe);
   endproperty
   a_start: assert property (p_start)
      else $error("start not taken");

   property p_stop;
      @(posedge link_clk_in) disable iff (link_rst) (stop_c && act) |=> l_r.st == ST_IDLE;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop not taken");

   property p_shift;
      @(posedge link_clk_in) disable iff (link_rst)
         (act && l_r.st == ST_RX && scl_rise) |=> l_r.sh[0] == $past(sda_f);
   endproperty
   a_shift: assert property (p_shift)
      else $error("received bit not shifted in");

   property p_nomatch;
      @(posedge link_clk_in) disable iff (link_rst)
         (act && l_r.st == ST_RX && scl_fall && l_r.bitcnt == LAST_BIT
          && l_r.bytenum == 2'h0 && l_r.sh[7:1] != {DEV_ADDR_HI, l_r.adr_lsb})
         |=> (l_r.st == ST_IDLE && !l_r.oe) ##1 !l_r.oe;
   endproperty
   a_nomatch: assert property (p_nomatch)
      else $error("foreign address acknowledged");

   property p_write_req;
      @(posedge link_clk_in) disable iff (link_rst)
         (act && l_r.st == ST_RX && scl_fall && l_r.bitcnt == LAST_BIT
          && l_r.bytenum == 2'h2)
         |=> (l_r.req_we && l_r.req_tgl != $past(l_r.req_tgl) && l_r.oe);
   endproperty
   a_write_req: assert property (p_write_req)
      else $error("data byte not sent to register file");

   property p_read_load;
      @(posedge link_clk_in) disable iff (link_rst)
         (act && l_r.st == ST_ACK && scl_fall && l_r.rw)
         |=> (l_r.sh == $past(l_r.rdata) && l_r.oe == !$past(l_r.rdata[7]));
   endproperty
   a_read_load: assert property (p_read_load)
      else $error("read byte not loaded");

   property p_nack_end;
      @(posedge link_clk_in) disable iff (link_rst)
         (act && l_r.st == ST_MACK && scl_fall && l_r.nack)
         |=> (l_r.st == ST_IDLE && !l_r.oe);
   endproperty
   a_nack_end: assert property (p_nack_end)
      else $error("data not released after not-acknowledge");

   property p_gain;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
         r_r.sw_mode |-> r_r.gain == $past(r_r.regs[ANA_CTRL_IDX][AGAIN_MSB:AGAIN_LSB]);
   endproperty
   a_gain: assert property (p_gain)
      else $error("analog gain does not follow its register field");

   c_write: cover property (@(posedge link_clk_in) disable iff (link_rst)
      $rose(l_r.req_we));
   c_read: cover property (@(posedge link_clk_in) disable iff (link_rst)
      l_r.st == ST_MACK && scl_fall && l_r.nack);
   c_mismatch: cover property (@(posedge link_clk_in) disable iff (link_rst)
      $past(l_r.st == ST_RX) && l_r.st == ST_IDLE && l_r.bytenum == 2'h0);
   c_sw_mode: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(r_r.sw_mode));

endmodule

// file: icp_master_model.sv
// Behavioural two-wire bus master that faces the control port.
`timescale 1ns/1ps
module icp_master_model (
   // Bus lines; the clock has a pull-up, the data line is open drain
   output logic scl_out,
   output logic sda_low_out,
   input wire logic sda_in
);
   // Half bit period; 1250 ns is the fast rate, 5000 ns the standard rate.
   int half_ns = 1250;
   // Data moves this long after a clock fall, so it never races the edge.
   int skew_ns = 100;

   // Both lines idle released.
   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   // ************************************************************
   // Framing
   // ************************************************************

   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      #(skew_ns) sda_low_out = 1'b0;
      #(half_ns - skew_ns) scl_out = 1'b1;
      #(half_ns) sda_low_out = 1'b1;
      #(half_ns) scl_out = 1'b0;
   endtask

   // Stop releases the bus after the last byte.
   task automatic stop();
      #(skew_ns) sda_low_out = 1'b1;
      #(half_ns - skew_ns) scl_out = 1'b1;
      #(half_ns) sda_low_out = 1'b0;
      #(half_ns);
   endtask

   // ************************************************************
   // Bytes
   // ************************************************************

   // Sends eight bits MSB first; ack is set only if data is low at the start and at the end of the high time.
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic first;
      for (int i = 7; i >= 0; i--)
      begin
         #(skew_ns) sda_low_out = ~b[i];
         #(half_ns - skew_ns) scl_out = 1'b1;
         #(half_ns) scl_out = 1'b0;
      end
      #(skew_ns) sda_low_out = 1'b0;
      #(half_ns - skew_ns) scl_out = 1'b1;
      first = sda_in;
      #(half_ns) ack = ~first & ~sda_in;
      scl_out = 1'b0;
   endtask

   // Takes eight bits, then answers with acknowledge or not-acknowledge.
   task automatic get_byte(input logic nack, output logic [7:0] b);
      sda_low_out = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         #(half_ns) scl_out = 1'b1;
         b[i] = sda_in;
         #(half_ns) scl_out = 1'b0;
      end
      #(skew_ns) sda_low_out = ~nack;
      #(half_ns - skew_ns) scl_out = 1'b1;
      #(half_ns) scl_out = 1'b0;
   endtask
endmodule

// file: tb.sv
// Self-checking bench for the two-wire register control port.
`timescale 1ns/1ps
module tb;
   import icp_pkg::*;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic strap = 1'b0;
   logic [1:0] gain_pins = 2'h3;
   logic scl, sda_low, sda_oe, sda_o, sw_mode;
   logic [1:0] again;
   logic [7:0] rd_data;
   int miscompares = 0;
   int checks_done = 0;
   // Identification value handed to the port; the value is arbitrary.
   localparam logic [7:0] ID_VAL = 8'h3c;
   // Wired-AND data line: low when the master pulls it or the port drives a low.
   wire sda = ~sda_low & (~sda_oe | sda_o);

   // Clocks of the two domains, unrelated in phase.
   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end
   initial
   begin
      #7;
      forever #15 link_clk = ~link_clk;
   end

   icp_ctrl_port #(.DEVICE_ID(ID_VAL)) icp_ctrl_port_inst (.ref_clk_in(ref_clk),
      .sys_rst_in(sys_rst),
      .link_clk_in(link_clk), .sleep_address_select_pin_in(strap),
      .gain_select_pins_in(gain_pins), .bridge_mode_or_bus_clock_pin_in(scl),
      .switch_freq_or_bus_data_pin_in(sda), .switch_freq_or_bus_data_pin_out(sda_o),
      .switch_freq_or_bus_data_pin_oe_out(sda_oe), .sw_mode_out(sw_mode),
      .analog_gain_out(again));
   icp_master_model icp_master_model_inst (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda));

   // ************************************************************
   // Helpers
   // ************************************************************

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Sends one byte and compares the acknowledge seen with the one expected.
   task automatic xfer(input logic [7:0] b, input logic exp_ack);
      logic a;
      icp_master_model_inst.put_byte(b, a);
      check({7'h0, a}, {7'h0, exp_ack});
   endtask

   // The link reset needs several link edges, so reset spans twelve cycles.
   task automatic do_reset(input logic s);
      @(negedge ref_clk);
      sys_rst = 1'b1;
      strap = s;
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      #2000;
   endtask

   task automatic close_out();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************

   task automatic t_write();
      // Index 2 is written first, then the analog control register sets gain 2.
      icp_master_model_inst.start();
      xfer(8'hd8, 1'b1);
      xfer(8'h02, 1'b1);
      xfer(8'h14, 1'b1);
      icp_master_model_inst.stop();
      icp_master_model_inst.start();
      xfer(8'hd8, 1'b1);
      xfer(ANA_CTRL_IDX, 1'b1);
      xfer(8'h0a, 1'b1);
      icp_master_model_inst.stop();
      repeat (20) @(negedge ref_clk);
      check({6'h0, again}, 8'h02);
   endtask

   // Read at the standard rate ends with not-acknowledge and stop.
   task automatic t_read();
      icp_master_model_inst.half_ns = 5000;
      icp_master_model_inst.start();
      xfer(8'hd8, 1'b1);
      xfer(ANA_CTRL_IDX, 1'b1);
      icp_master_model_inst.start();
      xfer(8'hd9, 1'b1);
      icp_master_model_inst.get_byte(1'b1, rd_data);
      icp_master_model_inst.stop();
      check(rd_data, 8'h0a);
      check({7'h0, sda_oe}, 8'h00);
      icp_master_model_inst.half_ns = 1250;
   endtask

   task automatic t_bad_addr();
      icp_master_model_inst.start();
      xfer(8'hda, 1'b0);
      xfer(ANA_CTRL_IDX, 1'b0);
      icp_master_model_inst.stop();
   endtask

   // Outside software mode the gain follows the pins and the port stays silent.
   task automatic t_hw_mode();
      @(negedge ref_clk);
      gain_pins = 2'h1;
      repeat (20) @(negedge ref_clk);
      check({7'h0, sw_mode}, 8'h00);
      check({6'h0, again}, 8'h01);
      icp_master_model_inst.start();
      xfer(8'hd8, 1'b0);
      icp_master_model_inst.stop();
      @(negedge ref_clk);
      gain_pins = 2'h3;
      repeat (20) @(negedge ref_clk);
      check({7'h0, sw_mode}, 8'h01);
      check({6'h0, again}, 8'h02);
   endtask

   // A fresh power-up with the strap high moves the address.
   task automatic t_strap_high();
      do_reset(1'b1);
      icp_master_model_inst.start();
      xfer(8'hd8, 1'b0);
      icp_master_model_inst.stop();
      icp_master_model_inst.start();
      xfer(8'hda, 1'b1);
      xfer(DEV_ID_IDX, 1'b1);
      icp_master_model_inst.start();
      xfer(8'hdb, 1'b1);
      // The master acknowledges the first byte, so the next index follows.
      icp_master_model_inst.get_byte(1'b0, rd_data);
      check(rd_data, ID_VAL);
      icp_master_model_inst.get_byte(1'b1, rd_data);
      check(rd_data, 8'h00);
      icp_master_model_inst.stop();
      check({7'h0, sda_oe}, 8'h00);
   endtask

   // Main sequence.
   initial
   begin
      do_reset(1'b0);
      check({7'h0, sda_oe}, 8'h00);
      check({7'h0, sda_o}, 8'h00);
      check({6'h0, again}, 8'h00);
      t_write();
      t_read();
      t_bad_addr();
      t_hw_mode();
      t_strap_high();
      close_out();
   end

   // Watchdog sized well past the expected run of about 0.8 ms.
   initial
   begin
      #1800000;
      miscompares++;
      close_out();
   end
endmodule
